// ==== hw/relay_compare.sv ====
// Threshold comparator with hysteresis for one drive quantity.
// Assumes value, threshold and band share one unit and come from the same clock.
`include "relay_map.svh"

module relay_compare
  import relay_pkg::*;
#(
  parameter bit BELOW = 1'b0
)
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire level_t value_in,
  input wire level_t threshold_in,
  input wire level_t band_in,
  output logic active_out
);

  logic [16:0] value_plus_band;
  logic [16:0] thresh_plus_band;
  logic set_cond;
  logic clear_cond;

  assign value_plus_band = {1'b0, value_in} + {1'b0, band_in};
  assign thresh_plus_band = {1'b0, threshold_in} + {1'b0, band_in};

  always_comb
  begin
    if (BELOW)
    begin
      set_cond = value_in < threshold_in;
      clear_cond = {1'b0, value_in} >= thresh_plus_band;
    end
    else
    begin
      set_cond = value_in >= threshold_in;
      clear_cond = value_plus_band < {1'b0, threshold_in};
    end
  end

  // Between the two edges the state holds
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      active_out <= 1'b0;
    else if (set_cond)
      active_out <= 1'b1;
    else if (clear_cond)
      active_out <= 1'b0;
  end

endmodule : relay_compare

// ==== hw/relay_map.svh ====
// Register offsets, field positions, reset values and limits of the relay selector.
// Assumes a 16-bit plain register port with byte offsets on an 8-bit address.
`ifndef RELAY_MAP_SVH
`define RELAY_MAP_SVH

`define RELAY_ADDR_W 8
`define RELAY_DATA_W 16

`define RELAY_OFS_FUNC 8'h00
`define RELAY_OFS_THRESH 8'h04
`define RELAY_OFS_BAND 8'h08
`define RELAY_OFS_STATUS 8'h0c
`define RELAY_OFS_COUNT 8'h10

// Levels in tenths of a percent
`define RELAY_FUNC_RESET 4'h1
`define RELAY_FUNC_MAX 16'h000c
`define RELAY_THRESH_RESET 16'h03e8
`define RELAY_THRESH_MAX 16'h07d0
`define RELAY_BAND_RESET 16'h0000
`define RELAY_BAND_MAX 16'h03e8

// Fieldbus control word bit that drives the relay
`define RELAY_CTRL_BIT 8

// Status register fields
`define RELAY_ST_COIL 0
`define RELAY_ST_CMP_LSB 1
`define RELAY_ST_CMP_MSB 5
`define RELAY_ST_REJECT 6
`define RELAY_ST_FIRE 7
`define RELAY_ST_TRIP 8

`endif

// ==== hw/relay_output_selector.sv ====
// Relay output selector: picks the drive condition that energises the relay coil.
// Assumes drive status comes from core logic on clock_in, so it needs no synchroniser.
//
// Chosen here: the plain strobed port and the address map.
`include "relay_map.svh"

module relay_output_selector
  import relay_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire drive_status_s drive_in,
  input wire logic [`RELAY_ADDR_W-1:0] addr_in,
  input wire logic [`RELAY_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`RELAY_DATA_W-1:0] rdata_out,
  output level_t threshold_out,
  output logic [4:0] compare_out,
  output logic relay_coil_out
);

  localparam int NUM_CMP = 5;

  relay_func_e func_sel;
  level_t threshold;
  level_t band;
  logic reject;
  logic [15:0] toggle_count;
  logic relay;
  logic next_relay;
  logic cond;
  logic [NUM_CMP-1:0] cmp_active;
  level_t cmp_value [NUM_CMP];

  // Write decode
  logic wr_func;
  logic wr_thresh;
  logic wr_band;
  logic wr_status;
  logic wr_count;
  logic func_ok;
  logic thresh_ok;
  logic band_ok;
  logic bad_write;
  logic relay_changes;

  assign wr_func = wr_in && (addr_in == `RELAY_OFS_FUNC);
  assign wr_thresh = wr_in && (addr_in == `RELAY_OFS_THRESH);
  assign wr_band = wr_in && (addr_in == `RELAY_OFS_BAND);
  assign wr_status = wr_in && (addr_in == `RELAY_OFS_STATUS);
  assign wr_count = wr_in && (addr_in == `RELAY_OFS_COUNT);

  // Out-of-range values are refused and flagged
  assign func_ok = wdata_in <= `RELAY_FUNC_MAX;
  assign thresh_ok = wdata_in <= `RELAY_THRESH_MAX;
  assign band_ok = wdata_in <= `RELAY_BAND_MAX;

  assign bad_write = (wr_func && !func_ok)
    || (wr_thresh && !thresh_ok)
    || (wr_band && !band_ok);

  // Function select register
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      func_sel <= relay_func_e'(`RELAY_FUNC_RESET);
    else if (wr_func && func_ok)
      func_sel <= relay_func_e'(wdata_in[3:0]);
  end

  // Threshold register
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      threshold <= `RELAY_THRESH_RESET;
    else if (wr_thresh && thresh_ok)
      threshold <= wdata_in;
  end

  // Hysteresis band register
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      band <= `RELAY_BAND_RESET;
    else if (wr_band && band_ok)
      band <= wdata_in;
  end

  // Sticky reject flag; a new refusal wins over the clear
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      reject <= 1'b0;
    else if (bad_write)
      reject <= 1'b1;
    else if (wr_status && wdata_in[`RELAY_ST_REJECT])
      reject <= 1'b0;
  end

  // Threshold is shared with the analog output selector
  assign threshold_out = threshold;

  // Comparator inputs in channel order
  always_comb
  begin
    cmp_value[CMP_FREQ_HI] = drive_in.out_freq;
    cmp_value[CMP_CURR_HI] = drive_in.motor_current;
    cmp_value[CMP_FREQ_LO] = drive_in.out_freq;
    cmp_value[CMP_CURR_LO] = drive_in.motor_current;
    cmp_value[CMP_AIN2_HI] = drive_in.ain2_level;
  end

  // One hysteresis comparator per threshold condition
  for (genvar i = 0; i < NUM_CMP; i++)
  begin : g_cmp
    relay_compare #(
      .BELOW((i == CMP_FREQ_LO) || (i == CMP_CURR_LO))
    ) u_cmp (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .value_in(cmp_value[i]),
      .threshold_in(threshold),
      .band_in(band),
      .active_out(cmp_active[i])
    );
  end

  assign compare_out = cmp_active;

  // Condition chosen by the function select
  always_comb
  begin
    unique case (func_sel)
      FN_RUNNING:
        cond = drive_in.running;
      FN_HEALTHY:
        cond = drive_in.healthy && !drive_in.tripped;
      FN_AT_SPEED:
        cond = drive_in.at_speed;
      FN_TRIPPED:
        cond = drive_in.tripped;
      FN_FREQ_HI:
        cond = cmp_active[CMP_FREQ_HI];
      FN_CURR_HI:
        cond = cmp_active[CMP_CURR_HI];
      FN_FREQ_LO:
        cond = cmp_active[CMP_FREQ_LO];
      FN_CURR_LO:
        cond = cmp_active[CMP_CURR_LO];
      FN_AIN2_HI:
        cond = cmp_active[CMP_AIN2_HI];
      FN_READY:
        cond = drive_in.ready && !drive_in.tripped;
      FN_FIRE:
        cond = drive_in.fire_mode;
      FN_FREQ_HI_NOFIRE:
        cond = cmp_active[CMP_FREQ_HI];
      FN_FIELDBUS:
        cond = drive_in.ctrl_word[`RELAY_CTRL_BIT];
      default:
        cond = 1'b0;
    endcase
  end

  // Setting 11 freezes the relay while fire mode is active
  always_comb
  begin
    if (func_sel == FN_FREQ_HI_NOFIRE && drive_in.fire_mode)
      next_relay = relay;
    else
      next_relay = cond;
  end

  // Relay coil drive; high closes the contacts
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      relay <= 1'b0;
    else
      relay <= next_relay;
  end

  assign relay_coil_out = relay;

  // Contact operation counter, saturating; a write restarts it at 0, or at 1 if the relay changes in that cycle
  assign relay_changes = next_relay != relay;

  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      toggle_count <= 16'h0000;
    else if (wr_count)
      toggle_count <= {15'h0000, relay_changes};
    else if (relay_changes && toggle_count != 16'hffff)
      toggle_count <= toggle_count + 16'h0001;
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rdata_out <= 16'h0000;
    else if (rd_in)
    begin
      unique case (addr_in)
        `RELAY_OFS_FUNC:
          rdata_out <= {12'h000, func_sel};
        `RELAY_OFS_THRESH:
          rdata_out <= threshold;
        `RELAY_OFS_BAND:
          rdata_out <= band;
        `RELAY_OFS_STATUS:
        begin
          rdata_out <= 16'h0000;
          rdata_out[`RELAY_ST_COIL] <= relay;
          rdata_out[`RELAY_ST_CMP_MSB:`RELAY_ST_CMP_LSB] <= cmp_active;
          rdata_out[`RELAY_ST_REJECT] <= reject;
          rdata_out[`RELAY_ST_FIRE] <= drive_in.fire_mode;
          rdata_out[`RELAY_ST_TRIP] <= drive_in.tripped;
        end
        `RELAY_OFS_COUNT:
          rdata_out <= toggle_count;
        default:
          rdata_out <= 16'h0000;
      endcase
    end
    else
      rdata_out <= 16'h0000;
  end

endmodule : relay_output_selector

// ==== hw/relay_pkg.sv ====
// Types shared by the relay output selector and its threshold comparator.
// Assumes relay_map.svh supplies all numeric constants.
package relay_pkg;

  typedef logic [15:0] level_t;

  typedef enum logic [3:0] {
    FN_RUNNING = 4'h0,
    FN_HEALTHY = 4'h1,
    FN_AT_SPEED = 4'h2,
    FN_TRIPPED = 4'h3,
    FN_FREQ_HI = 4'h4,
    FN_CURR_HI = 4'h5,
    FN_FREQ_LO = 4'h6,
    FN_CURR_LO = 4'h7,
    FN_AIN2_HI = 4'h8,
    FN_READY = 4'h9,
    FN_FIRE = 4'ha,
    FN_FREQ_HI_NOFIRE = 4'hb,
    FN_FIELDBUS = 4'hc
  } relay_func_e;

  // Comparator channel order
  typedef enum logic [2:0] {
    CMP_FREQ_HI = 3'h0,
    CMP_CURR_HI = 3'h1,
    CMP_FREQ_LO = 3'h2,
    CMP_CURR_LO = 3'h3,
    CMP_AIN2_HI = 3'h4
  } cmp_chan_e;

  typedef struct packed {
    logic running;
    logic healthy;
    logic at_speed;
    logic tripped;
    logic ready;
    logic fire_mode;
    level_t out_freq;
    level_t motor_current;
    level_t ain2_level;
    logic [15:0] ctrl_word;
  } drive_status_s;

endpackage : relay_pkg

// ==== test/relay_checker.sv ====
// Port checks of the relay output selector.
// Assumes it is bound to relay_output_selector.
`include "relay_map.svh"

module relay_checker
  import relay_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire drive_status_s drive_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire level_t threshold_out,
  input wire logic [4:0] compare_out,
  input wire logic relay_coil_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  logic thr_wr;
  logic live;
  level_t band_seen;
  assign thr_wr = wr_in && addr_in == `RELAY_OFS_THRESH;
  // Comparators stay in reset state until the first edge after release
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      live <= 1'b0;
    else
      live <= 1'b1;
  end
  // Shadow of the hysteresis band, from accepted writes
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      band_seen <= `RELAY_BAND_RESET;
    else if (wr_in && addr_in == `RELAY_OFS_BAND && wdata_in <= `RELAY_BAND_MAX)
      band_seen <= wdata_in;
  end
  freq_high_a: assert property (live && drive_in.out_freq >= threshold_out |=> compare_out[0])
    else $error("freq high missed");
  curr_high_a: assert property (live && drive_in.motor_current >= threshold_out |=>
    compare_out[1]) else $error("current high missed");
  freq_low_a: assert property (live && drive_in.out_freq < threshold_out |=> compare_out[2])
    else $error("freq low missed");
  curr_low_a: assert property (live && drive_in.motor_current < threshold_out |=>
    compare_out[3]) else $error("current low missed");
  ain_high_a: assert property (live && drive_in.ain2_level >= threshold_out |=>
    compare_out[4]) else $error("analog high missed");
  high_release_a: assert property ($fell(compare_out[0]) |->
    17'($past(drive_in.out_freq)) + 17'($past(band_seen)) < 17'($past(threshold_out)))
    else $error("early release");
  thr_write_a: assert property (thr_wr && wdata_in <= `RELAY_THRESH_MAX |=>
    threshold_out == $past(wdata_in)) else $error("threshold not stored");
  thr_refuse_a: assert property (thr_wr && wdata_in > `RELAY_THRESH_MAX |=>
    $stable(threshold_out)) else $error("threshold not refused");
  status_coil_a: assert property (rd_in && addr_in == `RELAY_OFS_STATUS |=>
    rdata_out[0] == $past(relay_coil_out)) else $error("status coil wrong");
  cover property ($rose(relay_coil_out));
  cover property ($fell(compare_out[0]));
  cover property (thr_wr && wdata_in > `RELAY_THRESH_MAX);
endmodule : relay_checker

bind relay_output_selector relay_checker chk (.clock_in(clock_in), .arst_n_in(arst_n_in),
  .drive_in(drive_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .threshold_out(threshold_out), .compare_out(compare_out),
  .relay_coil_out(relay_coil_out));

// ==== test/relay_load.sv ====
// Load wired across the relay contacts.
// Assumes ideal contacts with no bounce.
module relay_load
(
  input wire logic coil_in,
  output logic closed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign closed_out = coil_in;
endmodule : relay_load

// ==== test/tb.sv ====
// Self-checking bench of the relay output selector with a contact load.
// Assumes one 200 MHz clock and the relay_map.svh constants.
`include "relay_map.svh"

module tb import relay_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  drive_status_s d = '0;
  drive_status_s s = '0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] thr;
  logic coil;
  logic closed;
  int errors = 0;
  int cmp_count = 0;

  relay_output_selector dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .drive_in(d),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .threshold_out(thr), .compare_out(), .relay_coil_out(coil));
  relay_load load (.coil_in(coil), .closed_out(closed));

  initial
  begin
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic wreg(input logic [7:0] a, input logic [15:0] x);
    @(posedge clock_in);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    cmp("rdata", e, rdata);
  endtask : rreg

  // Apply drive state, let comparator and relay settle
  task automatic put(input logic e);
    @(posedge clock_in);
    d <= s;
    repeat (3) @(posedge clock_in);
    #1;
    cmp("contacts", {15'h0000, e}, {15'h0000, closed});
  endtask : put

  initial
  begin
    repeat (2000) @(posedge clock_in);
    errors++;
    print_verdict();
  end

  initial
  begin
    repeat (8) @(posedge clock_in);
    arst_n_in <= 1'b1;
    s.healthy = 1'b1;
    put(1'b1);
    rreg(`RELAY_OFS_FUNC, 16'h0001);
    rreg(`RELAY_OFS_THRESH, 16'h03e8);
    rreg(`RELAY_OFS_BAND, 16'h0000);
    rreg(`RELAY_OFS_STATUS, 16'h0019);
    s.tripped = 1'b1;
    put(1'b0);
    wreg(`RELAY_OFS_FUNC, 16'h0009);
    s.ready = 1'b1;
    put(1'b0);
    s.tripped = 1'b0;
    put(1'b1);
    wreg(`RELAY_OFS_FUNC, 16'h0000);
    s.running = 1'b1;
    put(1'b1);
    wreg(`RELAY_OFS_FUNC, 16'h0002);
    s.at_speed = 1'b1;
    put(1'b1);
    wreg(`RELAY_OFS_FUNC, 16'h0003);
    put(1'b0);
    wreg(`RELAY_OFS_FUNC, 16'h000a);
    s.fire_mode = 1'b1;
    put(1'b1);
    s.fire_mode = 1'b0;
    wreg(`RELAY_OFS_FUNC, 16'h000c);
    s.ctrl_word = 16'h0100;
    put(1'b1);
    s.ctrl_word = 16'hfeff;
    put(1'b0);
    for (int f = 4; f <= 8; f++)
    begin
      wreg(`RELAY_OFS_FUNC, 16'(f));
      s.out_freq = 16'h03e8;
      s.motor_current = 16'h03e7;
      s.ain2_level = 16'h03e8;
      put(f != 5 && f != 6);
      s.out_freq = 16'h03e7;
      s.motor_current = 16'h03e8;
      s.ain2_level = 16'h03e7;
      put(f == 5 || f == 6);
    end
    wreg(`RELAY_OFS_FUNC, 16'h0004);
    wreg(`RELAY_OFS_BAND, 16'h0032);
    s.out_freq = 16'h03e8;
    put(1'b1);
    s.out_freq = 16'h03b6;
    put(1'b1);
    s.out_freq = 16'h03b5;
    put(1'b0);
    wreg(`RELAY_OFS_FUNC, 16'h000b);
    s.out_freq = 16'h03e8;
    put(1'b1);
    s.fire_mode = 1'b1;
    s.out_freq = 16'h0000;
    put(1'b1);
    s.fire_mode = 1'b0;
    put(1'b0);
    wreg(`RELAY_OFS_FUNC, 16'h000d);
    rreg(`RELAY_OFS_FUNC, 16'h000b);
    wreg(`RELAY_OFS_THRESH, 16'h07d1);
    rreg(`RELAY_OFS_THRESH, 16'h03e8);
    wreg(`RELAY_OFS_THRESH, 16'h07d0);
    rreg(`RELAY_OFS_THRESH, 16'h07d0);
    cmp("threshold", 16'h07d0, thr);
    wreg(`RELAY_OFS_BAND, 16'h03e9);
    rreg(`RELAY_OFS_BAND, 16'h0032);
    rreg(`RELAY_OFS_STATUS, 16'h0058);
    wreg(`RELAY_OFS_STATUS, 16'h0040);
    rreg(`RELAY_OFS_STATUS, 16'h0018);
    wreg(`RELAY_OFS_COUNT, 16'h0000);
    s.out_freq = 16'h07d0;
    put(1'b1);
    rreg(`RELAY_OFS_COUNT, 16'h0001);
    rreg(8'h14, 16'h0000);
    print_verdict();
  end
endmodule : tb
